//--- include/adcsc_pkg.sv
// Purpose: shared constants and types of the converter control block
// Assumes: 8-bit i/o register bus, 6-bit i/o address
// Notes:   offsets are i/o addresses of the register file
package adcsc_pkg;

    //////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [5:0] ADDR_CTRL_B = 6'h03;
    localparam logic [5:0] ADDR_RES_LO = 6'h04;
    localparam logic [5:0] ADDR_RES_HI = 6'h05;
    localparam logic [5:0] ADDR_CSR    = 6'h06;
    localparam logic [5:0] ADDR_MUX    = 6'h07;
    localparam logic [7:0] REG_RESET   = 8'h00;

    //////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int EN_BIT    = 7;
    localparam int START_BIT = 6;
    localparam int ATE_BIT   = 5;
    localparam int FLAG_BIT  = 4;
    localparam int IE_BIT    = 3;
    localparam int LAR_BIT   = 5;
    localparam int REFX_BIT  = 4;
    localparam int MUXX_BIT  = 3;

    //////////////////////////////////////////////////////////////////////////
    // timing and codes
    localparam logic [4:0] LONG_CYC  = 5'd25;
    localparam logic [4:0] SHORT_CYC = 5'd13;
    localparam logic [5:0] TEMP_CHAN = 6'h3f;
    localparam logic [2:0] TS_FREE   = 3'h0;

    typedef enum logic [2:0] {
        ADCSC_REF_SUPPLY,
        ADCSC_REF_EXT_PIN,
        ADCSC_REF_INT_1V1,
        ADCSC_REF_RESERVED,
        ADCSC_REF_INT_2V56,
        ADCSC_REF_INT_2V56_BYP
    } adcsc_ref_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [5:0] addr;
        logic [7:0] wdata;
    } adcsc_io_req_t;

    typedef struct packed {
        logic       power;
        logic       sample;
        logic       temp_en;
        logic [5:0] chan;
        adcsc_ref_t ref_src;
    } adcsc_afe_t;

endpackage

//--- rtl/adcsc_top.sv
// Purpose: control, sequencing and result registers of a 10-bit converter
// Assumes: analog result is quasi-static when a conversion ends
// Notes:   register reads answer one cycle after the read strobe
//
// Summary of operation
// - channel code 111111 routes and enables the temperature sensor.
// - enable bit powers converter; clearing it aborts a running conversion.
// - start bit begins each single conversion, or the first free-running one.
// - first conversion after enabling or a reference change lasts 25 converter cycles, others 13.
// - start bit reads one while converting; writing zero does nothing.
// - with auto-trigger set, rising edge of selected source starts conversion.
// - completion flag sets at finish; clears on vector ack or write one.
// - interrupt request while flag, enable and global enable all set.
// - prescaler codes give divide by 2,2,4,8,16,32,64,128.
// - right adjusted: high holds bits 9:8, low holds bits 7:0.
// - left adjusted: high holds bits 9:2, low bits 1:0 at 7:6.
// - reading low locks both result registers until high is read.
// - reference code selects supply, pin, 1.1V, reserved or 2.56V sources.
// - reference and channel changes apply only after current conversion ends.
// - after a reference change the next conversion lasts 25 cycles.
// - channel extension bit is the top bit of the channel code.
// - reference extension bit is the top bit of the reference code.
// - left-adjust change alters result presentation at once.
`timescale 1ns/10ps
module adcsc_top (
    // clock and reset
    input  wire logic                     sys_clk,
    input  wire logic                     srst,
    // i/o register bus
    input  wire adcsc_pkg::adcsc_io_req_t io_req,
    output logic [7:0]                    io_rdata,
    // processor interrupt
    input  wire logic                     global_irq_enable,
    input  wire logic                     irq_vector_ack,
    output logic                          irq_request,
    // trigger sources
    input  wire logic [7:0]               trigger_sources,
    // analog front end
    input  wire logic [9:0]               afe_result,
    output adcsc_pkg::adcsc_afe_t         afe_ctrl
);
    import adcsc_pkg::*;

    typedef enum logic [0:0] {ST_IDLE, ST_CONV} adcsc_state_t;

    ////////////////////////////////////////////////////////////////////////////
    // state
    logic         en;
    logic         start_req;
    logic         ate;
    logic         flag;
    logic         ie;
    logic [2:0]   ps;
    logic [1:0]   refs_lo;
    logic         lar;
    logic [4:0]   mux_lo;
    logic [1:0]   ctlb_hi;
    logic         ref_ext;
    logic         mux_ext;
    logic [2:0]   ts;
    adcsc_state_t state;
    logic [4:0]   cyc;
    logic         long_pend;
    logic         first_conv;
    logic [6:0]   presc;
    logic [9:0]   result;
    logic         lock;
    logic [5:0]   act_chan;
    logic [2:0]   act_ref;
    logic [7:0]   trig_prev;
    logic [9:0]   afe_meta;
    logic [9:0]   afe_sync;

    ////////////////////////////////////////////////////////////////////////////
    // decode
    wire       wr_csr    = io_req.wr && (io_req.addr == ADDR_CSR);
    wire       wr_mux    = io_req.wr && (io_req.addr == ADDR_MUX);
    wire       wr_ctlb   = io_req.wr && (io_req.addr == ADDR_CTRL_B);
    wire       rd_low    = io_req.rd && (io_req.addr == ADDR_RES_LO);
    wire       rd_high   = io_req.rd && (io_req.addr == ADDR_RES_HI);
    wire       busy      = (state == ST_CONV);
    wire       next_en   = wr_csr ? io_req.wdata[EN_BIT] : en;
    wire       set_start = wr_csr && io_req.wdata[START_BIT] && next_en;
    wire [5:0] next_chan = {mux_ext, mux_lo};
    wire [2:0] next_ref  = {ref_ext, refs_lo};
    wire       ref_chg   = !busy && (next_ref != act_ref);

    // converter clock tick from the prescaler
    wire [6:0] presc_mask = (ps < 3'h2) ? 7'h01 : 7'((8'h01 << ps) - 8'h01);
    wire       tick       = en && ((presc & presc_mask) == presc_mask);
    wire [4:0] conv_last  = long_pend ? LONG_CYC - 5'd1 : SHORT_CYC - 5'd1;
    wire       done       = busy && tick && (cyc == conv_last);
    wire       begin_conv = en && !busy && start_req;

    // trigger selection
    wire trig_edge  = trigger_sources[ts] && !trig_prev[ts];
    wire auto_start = ate && en && ((ts == TS_FREE) ? done : trig_edge);

    // reference decode
    adcsc_ref_t ref_src;
    assign ref_src = (act_ref[1:0] == 2'h0) ? ADCSC_REF_SUPPLY :
                     (act_ref[1:0] == 2'h1) ? ADCSC_REF_EXT_PIN :
                     (act_ref == 3'h2)      ? ADCSC_REF_INT_1V1 :
                     (act_ref == 3'h3)      ? ADCSC_REF_RESERVED :
                     (act_ref == 3'h6)      ? ADCSC_REF_INT_2V56 :
                                              ADCSC_REF_INT_2V56_BYP;

    // read presentation, follows left adjust at once
    wire [7:0] res_low  = lar ? {result[1:0], 6'h00} : result[7:0];
    wire [7:0] res_high = lar ? result[9:2] : {6'h00, result[9:8]};
    wire [7:0] csr_rd   = {en, start_req | busy, ate, flag, ie, ps};
    wire [7:0] mux_rd   = {refs_lo, lar, mux_lo};
    wire [7:0] ctlb_rd  = {ctlb_hi, 1'b0, ref_ext, mux_ext, ts};
    wire [7:0] rd_mux   = (io_req.addr == ADDR_RES_LO) ? res_low :
                          (io_req.addr == ADDR_RES_HI) ? res_high :
                          (io_req.addr == ADDR_CSR)    ? csr_rd :
                          (io_req.addr == ADDR_MUX)    ? mux_rd :
                          (io_req.addr == ADDR_CTRL_B) ? ctlb_rd : REG_RESET;

    ////////////////////////////////////////////////////////////////////////////
    // software registers
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            {en, ate, ie, ps} <= 6'h00;
            {refs_lo, lar, mux_lo} <= REG_RESET;
            {ctlb_hi, ref_ext, mux_ext, ts} <= 7'h00;
        end else begin
            if (wr_csr) begin
                en  <= io_req.wdata[EN_BIT];
                ate <= io_req.wdata[ATE_BIT];
                ie  <= io_req.wdata[IE_BIT];
                ps  <= io_req.wdata[2:0];
            end
            if (wr_mux) begin
                {refs_lo, lar, mux_lo} <= io_req.wdata;
            end
            if (wr_ctlb) begin
                {ctlb_hi, ref_ext, mux_ext, ts} <= {io_req.wdata[7:6], io_req.wdata[4:0]};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // prescaler and sequencer
    always_ff @(posedge sys_clk) begin
        if (srst || !en) begin
            presc <= 7'h00;
            state <= ST_IDLE;
            cyc   <= 5'h00;
        end else begin
            presc <= presc + 7'h01;
            if (begin_conv) begin
                state <= ST_CONV;
                cyc   <= 5'h00;
            end else if (done) begin
                state <= ST_IDLE;
            end else if (busy && tick) begin
                cyc <= cyc + 5'h01;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            start_req  <= 1'b0;
            long_pend  <= 1'b1;
            first_conv <= 1'b1;
            act_chan   <= 6'h00;
            act_ref    <= 3'h0;
            trig_prev  <= 8'h00;
        end else begin
            start_req <= next_en && ((start_req && !begin_conv) || set_start || auto_start);
            trig_prev <= trigger_sources;
            if (!en || ref_chg) begin
                long_pend <= 1'b1;
            end else if (done) begin
                long_pend <= 1'b0;
            end
            if (!en) begin
                first_conv <= 1'b1;
            end else if (done) begin
                first_conv <= 1'b0;
            end
            if (!busy) begin
                act_chan <= next_chan;
                act_ref  <= next_ref;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // result, flag, lock
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            afe_meta <= 10'h000;
            afe_sync <= 10'h000;
            result   <= 10'h000;
            lock     <= 1'b0;
            flag     <= 1'b0;
        end else begin
            afe_meta <= afe_result;
            afe_sync <= afe_meta;
            if (done && !lock) begin
                result <= afe_sync;
            end
            if (rd_high) begin
                lock <= 1'b0;
            end else if (rd_low) begin
                lock <= 1'b1;
            end
            if (done) begin
                flag <= 1'b1;
            end else if (irq_vector_ack || (wr_csr && io_req.wdata[FLAG_BIT])) begin
                flag <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            io_rdata    <= REG_RESET;
            irq_request <= 1'b0;
            afe_ctrl    <= '0;
        end else begin
            io_rdata         <= io_req.rd ? rd_mux : REG_RESET;
            irq_request      <= flag && ie && global_irq_enable;
            afe_ctrl.power   <= en;
            afe_ctrl.sample  <= begin_conv;
            afe_ctrl.temp_en <= (act_chan == TEMP_CHAN);
            afe_ctrl.chan    <= act_chan;
            afe_ctrl.ref_src <= ref_src;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    sequence s_disable_write;
        wr_csr && !io_req.wdata[EN_BIT];
    endsequence
    sequence s_div2_tick;
        (en && ps == 3'h0 && tick) ##1 (en && ps == 3'h0 && !wr_csr);
    endsequence

    property p_temp_sensor;
        act_chan == TEMP_CHAN |=> afe_ctrl.temp_en;
    endproperty
    a_temp_sensor: assert property (p_temp_sensor) else $error("sensor not enabled");

    property p_disable_abort;
        s_disable_write |=> !en ##1 (state == ST_IDLE && presc == 7'h00);
    endproperty
    a_disable_abort: assert property (p_disable_abort) else $error("disable no abort");

    property p_first_long;
        done && first_conv |-> cyc == 5'd24;
    endproperty
    a_first_long: assert property (p_first_long) else $error("first conversion length");

    property p_start_busy;
        busy && io_req.rd && (io_req.addr == ADDR_CSR) |=> io_rdata[START_BIT];
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("start bit low in conversion");

    property p_flag_set;
        done |=> flag ##1 (flag || $past(irq_vector_ack) || $past(wr_csr));
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set");

    property p_irq;
        flag && ie && global_irq_enable |=> irq_request;
    endproperty
    a_irq: assert property (p_irq) else $error("irq missing");

    property p_div2;
        s_div2_tick |-> !tick ##1 tick;
    endproperty
    a_div2: assert property (p_div2) else $error("prescale by two wrong");

    property p_lock_hold;
        lock && !rd_high |=> $stable(result);
    endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("locked result changed");

    property p_chan_hold;
        busy ##1 busy |-> $stable(act_chan) && $stable(act_ref);
    endproperty
    a_chan_hold: assert property (p_chan_hold) else $error("select changed mid conversion");

    property p_left_adjust;
        lar |-> res_high == result[9:2] && res_low[5:0] == 6'h00;
    endproperty
    a_left_adjust: assert property (p_left_adjust) else $error("left adjust wrong");

endmodule

//--- tb/adcsc_afe_model.sv
// Purpose: analog front end stand-in for the converter control bench
// Assumes: bench holds level steady through each conversion
// Notes:   unpowered output toggles so a stale value never passes
`timescale 1ns/10ps
module adcsc_afe_model (
    // clock
    input  wire logic                  sys_clk,
    // control from converter
    input  wire adcsc_pkg::adcsc_afe_t afe_ctrl,
    input  wire logic [9:0]            level,
    // analog result
    output logic [9:0]                 afe_result
);
    import adcsc_pkg::*;
    initial afe_result = 10'h2aa;
    always @(posedge sys_clk) begin
        if (afe_ctrl.power) begin
            afe_result <= level;
        end else begin
            afe_result <= ~afe_result;
        end
    end
endmodule

//--- tb/adc_sequencer_control_test.sv
// Purpose: self-checking bench of the converter control block
// Assumes: io bus driven at falling edge, read data sampled next fall
// Notes:   conversion length judged from irq_request rise
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; \
    $display("Error t=%0t got %h exp %h", $time, (a), (b)); end end
module adc_sequencer_control_test;
    import adcsc_pkg::*;
    logic          sys_clk = 1'b0;
    logic          srst = 1'b1;
    adcsc_io_req_t io_req = '0;
    logic [7:0]    io_rdata;
    logic          global_irq_enable = 1'b1;
    logic          irq_vector_ack = 1'b0;
    logic          irq_request;
    logic [7:0]    trigger_sources = 8'h00;
    logic [9:0]    afe_result;
    logic [9:0]    level = 10'h000;
    logic [9:0]    old;
    adcsc_afe_t    afe_ctrl;
    logic [7:0]    d;
    int            bad_count = 0;
    int            checks = 0;
    int            seed = 32'h1b1d;
    int            n;

    always #4 sys_clk = ~sys_clk;

    adcsc_top DUT (.sys_clk(sys_clk), .srst(srst), .io_req(io_req), .io_rdata(io_rdata),
        .global_irq_enable(global_irq_enable), .irq_vector_ack(irq_vector_ack),
        .irq_request(irq_request), .trigger_sources(trigger_sources),
        .afe_result(afe_result), .afe_ctrl(afe_ctrl));
    adcsc_afe_model afe (.sys_clk(sys_clk), .afe_ctrl(afe_ctrl), .level(level),
        .afe_result(afe_result));

    ////////////////////////////////////////////////////////////////////////////
    // bus tasks and expectations
    task automatic wr(input logic [5:0] a, input logic [7:0] v);
        @(negedge sys_clk);
        io_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(negedge sys_clk);
        io_req.wr = 1'b0;
    endtask
    task automatic rchk(input logic [5:0] a, input logic [7:0] e);
        @(negedge sys_clk);
        io_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge sys_clk);
        io_req.rd = 1'b0;
        `CHK(io_rdata, e)
    endtask
    task automatic wait_irq(output int c);
        c = 0;
        while (irq_request !== 1'b1 && c < 20000) begin
            @(negedge sys_clk);
            c++;
        end
        if (c >= 20000) begin
            bad_count++;
        end
    endtask
    task automatic conv(input logic [7:0] v, output int c);
        wr(ADDR_CSR, v);
        wait_irq(c);
    endtask
    task automatic clr(input logic [7:0] v);
        wr(ADDR_CSR, v);
        @(negedge sys_clk);
    endtask
    function automatic logic inwin(input int c, input int len, input int ps);
        int dv;
        dv = (ps < 2) ? 2 : (1 << ps);
        return c >= len * dv - dv && c <= len * dv + 8;
    endfunction
    function automatic adcsc_ref_t ref_exp(input logic [2:0] r);
        case (r[1:0])
            2'd0: return ADCSC_REF_SUPPLY;
            2'd1: return ADCSC_REF_EXT_PIN;
            2'd2: return r[2] ? ADCSC_REF_INT_2V56 : ADCSC_REF_INT_1V1;
            default: return r[2] ? ADCSC_REF_INT_2V56_BYP : ADCSC_REF_RESERVED;
        endcase
    endfunction
    task automatic print_verdict;
        $display("mismatches %0d of %0d checks", bad_count, checks);
        if (bad_count == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (50000) @(posedge sys_clk);
        bad_count++;
        print_verdict;
    end

    ////////////////////////////////////////////////////////////////////////////
    // scenarios
    initial begin
        repeat (16) @(negedge sys_clk);
        srst = 1'b0;
        for (int a = 3; a < 8; a++) begin
            rchk(6'(a), REG_RESET);
        end
        rchk(6'h10, 8'h00);
        for (int ps = 0; ps < 8; ps++) begin
            level = 10'($random(seed));
            wr(ADDR_CSR, 8'h00);
            conv(8'hc8 | 8'(ps), n);
            `CHK(inwin(n, 25, ps), 1'b1)
            clr(8'h98 | 8'(ps));
            `CHK(irq_request, 1'b0)
            conv(8'hc8 | 8'(ps), n);
            `CHK(inwin(n, 13, ps), 1'b1)
            rchk(ADDR_RES_LO, level[7:0]);
            rchk(ADDR_RES_HI, {6'h00, level[9:8]});
            clr(8'h98 | 8'(ps));
        end
        wr(ADDR_CSR, 8'hca);
        rchk(ADDR_CSR, 8'hca);
        wr(ADDR_CSR, 8'h8a);
        rchk(ADDR_CSR, 8'hca);
        wr(ADDR_MUX, 8'h45);
        repeat (2) @(negedge sys_clk);
        `CHK(afe_ctrl.chan, 6'h00)
        wait_irq(n);
        repeat (2) @(negedge sys_clk);
        `CHK(afe_ctrl.ref_src, ADCSC_REF_EXT_PIN)
        clr(8'h9a);
        level = 10'h2d3;
        conv(8'hca, n);
        `CHK(inwin(n, 25, 2), 1'b1)
        wr(ADDR_MUX, 8'h65);
        rchk(ADDR_RES_HI, 8'hb4);
        rchk(ADDR_RES_LO, 8'hc0);
        old = level;
        level = 10'($random(seed));
        clr(8'h9a);
        conv(8'hca, n);
        rchk(ADDR_RES_HI, old[9:2]);
        clr(8'h9a);
        wr(ADDR_CSR, 8'hc2);
        repeat (20) @(negedge sys_clk);
        wr(ADDR_CSR, 8'h02);
        repeat (300) @(negedge sys_clk);
        rchk(ADDR_CSR, 8'h02);
        `CHK(afe_ctrl.power, 1'b0)
        for (int r = 0; r < 8; r++) begin
            wr(ADDR_CTRL_B, {3'h0, 1'(r >> 2), 4'h0});
            wr(ADDR_MUX, {2'(r), 6'h00});
            repeat (2) @(negedge sys_clk);
            `CHK(afe_ctrl.ref_src, ref_exp(3'(r)))
        end
        wr(ADDR_CTRL_B, 8'h08);
        wr(ADDR_MUX, 8'h9f);
        repeat (2) @(negedge sys_clk);
        `CHK({afe_ctrl.temp_en, afe_ctrl.chan}, 7'h7f)
        `CHK(afe_ctrl.ref_src, ADCSC_REF_INT_1V1)
        wr(ADDR_CTRL_B, 8'h01);
        global_irq_enable = 1'b0;
        wr(ADDR_CSR, 8'ha8);
        trigger_sources = 8'h02;
        repeat (200) @(negedge sys_clk);
        rchk(ADDR_CSR, 8'hb8);
        `CHK(irq_request, 1'b0)
        global_irq_enable = 1'b1;
        repeat (2) @(negedge sys_clk);
        `CHK(irq_request, 1'b1)
        irq_vector_ack = 1'b1;
        @(negedge sys_clk);
        irq_vector_ack = 1'b0;
        rchk(ADDR_CSR, 8'ha8);
        print_verdict;
    end
endmodule
